// ==== design/port_arbitration_table_status.sv ====
// Arbitration table, channel status and load control behind AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Summary of operation
// - Channel enable bit 31 of control always reads one.
// - Any table write on an upstream instance sets the coherency flag, status bit 0.
// - Coherency flag stays set until the triggered load has fully latched.
// - Downstream instances always read the coherency flag as zero.
// - Coherency flag reads meaningful only while a table scheme is selected.
// - Status bit 1 shows flow-control initialisation still pending.
// - Eight read-write 4-bit phase fields packed low to high.
// - Invalid port entries are skipped with no delay.
// - Identifiers 0, 2, 3 are ports; 4 to 15 are reserved.
// - Reset table is 1,2,3,4,5,6,7,1 for phases 0 to 7.
// - Control bit 16 triggers load, reads zero, upstream only.
module port_arbitration_table_status #(
  parameter int         ADDR_W    = 12,
  parameter bit         UPSTREAM  = 1'b1,
  parameter logic [3:0] EGRESS_ID = 4'h0
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address channel
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // Write data channel
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // Write response channel
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // Read data channel
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Link status and arbitration timing
  input  wire logic              fc_init_pending,
  input  wire logic              arb_advance,
  // Arbitration result
  output logic [3:0]             grant_port,
  output logic [2:0]             grant_phase,
  output logic                   grant_valid,
  // Interrupt
  output logic                   irq
);
  // Refuse an address bus too narrow for the map
  if (ADDR_W < 12) begin : g_addr_check
    $error("ADDR_W must be at least 12");
  end
  // Refuse an egress identifier that names no port of the switch
  if (EGRESS_ID != arb_table_pkg::PORT_UP && EGRESS_ID != arb_table_pkg::PORT_TWO &&
      EGRESS_ID != arb_table_pkg::PORT_THREE) begin : g_egress_check
    $error("EGRESS_ID must name a port");
  end

  typedef struct packed {
    // Write request captured from either channel
    logic              aw_ok;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_ok;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    // Bus answer registers
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    // Registers seen by software
    logic [31:0]       tbl;
    logic [2:0]        sel;
    // Table load tracking
    logic              coh;
    logic              dirty;
    logic              start;
    logic              pend;
    // Link status and interrupts
    logic              neg;
    logic [1:0]        isr;
    logic [1:0]        imr;
    logic              irq;
  } st_t;

  localparam st_t ST_RST = '{
    aw_ok: 1'b0, aw_addr: '0, w_ok: 1'b0, w_data: '0, w_strb: '0,
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: '0,
    arready: 1'b1, rvalid: 1'b0, rdata: '0, rresp: '0,
    tbl: arb_table_pkg::TBL_RST, sel: '0, coh: 1'b0, dirty: 1'b0,
    start: 1'b0, pend: 1'b0, neg: 1'b0, isr: '0, imr: '0, irq: 1'b0
  };

  st_t s_r;
  st_t s_nxt;

  table_if tif ();

  // Aligned word match against a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    logic [ADDR_W-1:0] o;
    o = ADDR_W'(ofs);
    hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
  endfunction : hit

  // Byte-lane merge of write data into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) m[b*8 +: 8] = d[b*8 +: 8];
    end
    merge = m;
  endfunction : merge

  // Table is in use when a table-driven scheme is selected
  logic tbl_used;
  assign tbl_used = (s_r.sel != 3'h0);

  logic coh_seen;
  assign coh_seen = s_r.coh & tbl_used & UPSTREAM;

  // Channel handshakes completing at this edge
  logic aw_take;
  logic w_take;
  logic b_done;
  logic ar_take;
  logic r_done;
  assign aw_take = awvalid && s_r.awready;
  assign w_take  = wvalid && s_r.wready;
  assign b_done  = bready && s_r.bvalid;
  assign ar_take = arvalid && s_r.arready;
  assign r_done  = rready && s_r.rvalid;

  // Register addressed by the read request
  logic rd_ctl;
  logic rd_sts;
  logic rd_tbl;
  logic rd_isr;
  logic rd_imr;
  assign rd_ctl = hit(araddr, arb_table_pkg::CTL_OFS);
  assign rd_sts = hit(araddr, arb_table_pkg::STS_OFS);
  assign rd_tbl = hit(araddr, arb_table_pkg::TBL_OFS);
  assign rd_isr = hit(araddr, arb_table_pkg::ISR_OFS);
  assign rd_imr = hit(araddr, arb_table_pkg::IMR_OFS);

  // A queued load starts only once the loader is idle and its last done has been seen,
  // so the done of one load is never taken for the end of the next
  logic load_go;
  assign load_go = s_r.pend && !tif.busy && !s_r.start && !tif.done;

  // Read data decode
  logic [31:0] rd_word;
  logic        rd_err;
  always_comb begin
    rd_word = '0;
    rd_err = 1'b0;
    if (rd_ctl) begin
      rd_word[arb_table_pkg::ENABLE_BIT] = 1'b1;
      rd_word[arb_table_pkg::SEL_LSB +: arb_table_pkg::SEL_W] = s_r.sel;
      rd_word[arb_table_pkg::LOAD_BIT] = 1'b0;
    end else if (rd_sts) begin
      rd_word[arb_table_pkg::COH_BIT] = coh_seen;
      rd_word[arb_table_pkg::NEG_BIT] = s_r.neg;
    end else if (rd_tbl) begin
      rd_word = s_r.tbl;
    end else if (rd_isr) begin
      rd_word[arb_table_pkg::EV_W-1:0] = s_r.isr;
    end else if (rd_imr) begin
      rd_word[arb_table_pkg::EV_W-1:0] = s_r.imr;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Next state of bus slave, registers and load control
  always_comb begin
    logic       do_wr;
    logic       tbl_wr;
    logic [1:0] ev;
    do_wr = 1'b0;
    tbl_wr = 1'b0;
    ev = '0;
    s_nxt = s_r;
    s_nxt.start = 1'b0;

    // Pending input follows the link, end of pending is an event
    s_nxt.neg = fc_init_pending;
    ev[arb_table_pkg::EV_NEG_END] = s_r.neg & ~fc_init_pending;

    // Write address and data taken in either order
    if (aw_take) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (w_take) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (b_done) begin
      s_nxt.bvalid = 1'b0;
    end
    // One write in flight: a new one waits until the last response is taken
    do_wr = s_nxt.aw_ok && s_nxt.w_ok && !s_r.bvalid;

    // clear only when load completes
    // A table write that landed during the copy keeps the flag set
    if (tif.done) begin
      s_nxt.coh = s_r.dirty;
      s_nxt.dirty = 1'b0;
      ev[arb_table_pkg::EV_LOADED] = 1'b1;
    end

    // Register write effects
    if (do_wr) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = arb_table_pkg::RESP_OKAY;
      if (hit(s_nxt.aw_addr, arb_table_pkg::TBL_OFS)) begin
        s_nxt.tbl = merge(s_r.tbl, s_nxt.w_data, s_nxt.w_strb);
        tbl_wr = 1'b1;
      end else if (hit(s_nxt.aw_addr, arb_table_pkg::CTL_OFS)) begin
        if (s_nxt.w_strb[2]) begin
          s_nxt.sel = s_nxt.w_data[arb_table_pkg::SEL_LSB +: arb_table_pkg::SEL_W];
          if (s_nxt.w_data[arb_table_pkg::LOAD_BIT] && UPSTREAM) begin
            s_nxt.pend = 1'b1;
          end
        end
      end else if (hit(s_nxt.aw_addr, arb_table_pkg::ISR_OFS)) begin
        if (s_nxt.w_strb[0]) s_nxt.isr = s_r.isr & ~s_nxt.w_data[arb_table_pkg::EV_W-1:0];
      end else if (hit(s_nxt.aw_addr, arb_table_pkg::IMR_OFS)) begin
        if (s_nxt.w_strb[0]) s_nxt.imr = s_nxt.w_data[arb_table_pkg::EV_W-1:0];
      end else if (!hit(s_nxt.aw_addr, arb_table_pkg::STS_OFS)) begin
        s_nxt.bresp = arb_table_pkg::RESP_SLVERR;
      end
    end

    if (tbl_wr && UPSTREAM) begin
      s_nxt.coh = 1'b1;
      // A write during a load marks the copy stale
      if (tif.busy || s_r.start) s_nxt.dirty = 1'b1;
    end
    if (!UPSTREAM) begin
      s_nxt.coh = 1'b0;
      s_nxt.dirty = 1'b0;
    end

    // Launch a requested load once the loader is free
    // The copy reads the table live, so writes before the start need no second load
    if (load_go) begin
      s_nxt.pend = 1'b0;
      s_nxt.start = 1'b1;
      s_nxt.dirty = 1'b0;
    end

    // Read channel, one read outstanding
    if (r_done) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_word;
      s_nxt.rresp = rd_err ? arb_table_pkg::RESP_SLVERR : arb_table_pkg::RESP_OKAY;
    end

    // Ready flags registered for the next cycle
    // Readies drop as a channel is taken, so a second request waits for the answer
    s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_ok && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;

    // Sticky events, a set wins over a same-cycle clear
    s_nxt.isr = s_nxt.isr | ev;
    s_nxt.irq = |(s_nxt.isr & s_nxt.imr);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) s_r <= ST_RST;
    else s_r <= s_nxt;
  end

  assign tif.start = s_r.start;

  // Phase-by-phase copy into the arbiter
  phase_table_loader u_loader (
    .aclk    (aclk),
    .aresetn (aresetn),
    .shadow  (s_r.tbl),
    .tif     (tif.loader)
  );

  phase_sequencer #(
    .EGRESS_ID (EGRESS_ID)
  ) u_seq (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable      (tbl_used),
    .advance     (arb_advance),
    .tif         (tif.seq),
    .grant_port  (grant_port),
    .grant_phase (grant_phase),
    .grant_valid (grant_valid)
  );

  // Bus outputs straight from the state register
  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign irq = s_r.irq;
endmodule : port_arbitration_table_status

// ==== design/arb_table_pkg.sv ====
// Shared constants for the port arbitration table block
package arb_table_pkg;
  // Register byte offsets
  localparam logic [11:0] CTL_OFS   = 12'h214;
  localparam logic [11:0] STS_OFS   = 12'h218;
  localparam logic [11:0] TBL_OFS   = 12'h220;
  localparam logic [11:0] ISR_OFS   = 12'h230;
  localparam logic [11:0] IMR_OFS   = 12'h234;
  // Control and status field positions
  localparam int LOAD_BIT   = 16;
  localparam int SEL_LSB    = 17;
  localparam int SEL_W      = 3;
  localparam int ENABLE_BIT = 31;
  localparam int COH_BIT    = 0;
  localparam int NEG_BIT    = 1;
  // Interrupt event bits
  localparam int EV_LOADED  = 0;
  localparam int EV_NEG_END = 1;
  localparam int EV_W       = 2;
  // Table geometry and reset content
  localparam int PHASES     = 8;
  localparam int ID_W       = 4;
  localparam int IDX_W      = 3;
  localparam logic [31:0] TBL_RST = 32'h1765_4321;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
  // Port identifiers
  localparam logic [ID_W-1:0] PORT_UP    = 4'h0;
  localparam logic [ID_W-1:0] PORT_TWO   = 4'h2;
  localparam logic [ID_W-1:0] PORT_THREE = 4'h3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Entry names a real port other than the egress port
  function automatic logic port_usable(input logic [ID_W-1:0] id, input logic [ID_W-1:0] egress);
    port_usable = (id == PORT_UP || id == PORT_TWO || id == PORT_THREE) && (id != egress);
  endfunction : port_usable
endpackage : arb_table_pkg

// ==== design/table_if.sv ====
// Active table and load handshake between controller, loader and sequencer
`timescale 1ns/10ps
interface table_if;
  logic [31:0] active;
  logic        start;
  logic        busy;
  logic        done;
  modport ctrl (output start, input busy, input done);
  modport loader (input start, output active, output busy, output done);
  modport seq (input active);
endinterface : table_if

// ==== design/phase_table_loader.sv ====
// Copies the software table into the arbiter one phase per cycle
`timescale 1ns/10ps
module phase_table_loader (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Software table
  input  wire logic [31:0] shadow,
  // Load handshake and active table
  table_if.loader          tif
);
  typedef enum logic [0:0] {LD_IDLE = 1'b0, LD_COPY = 1'b1} ld_state_t;
  typedef struct packed {
    ld_state_t                        st;
    logic [arb_table_pkg::IDX_W-1:0]  idx;
    logic [31:0]                      active;
    logic                             done;
  } ld_t;
  localparam ld_t LD_RST = '{st: LD_IDLE, idx: '0, active: arb_table_pkg::TBL_RST, done: 1'b0};
  ld_t s_r;
  ld_t s_nxt;

  // Load sequence
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      LD_IDLE: begin
        if (tif.start) begin
          s_nxt.st = LD_COPY;
          s_nxt.idx = '0;
        end
      end
      LD_COPY: begin
        s_nxt.active[s_r.idx*arb_table_pkg::ID_W +: arb_table_pkg::ID_W] =
          shadow[s_r.idx*arb_table_pkg::ID_W +: arb_table_pkg::ID_W];
        s_nxt.idx = s_r.idx + 3'h1;
        if (s_r.idx == arb_table_pkg::IDX_LAST) begin
          s_nxt.st = LD_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt = LD_RST;
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) s_r <= LD_RST;
    else s_r <= s_nxt;
  end

  assign tif.active = s_r.active;
  assign tif.busy = (s_r.st == LD_COPY);
  assign tif.done = s_r.done;
endmodule : phase_table_loader

// ==== design/phase_sequencer.sv ====
// Walks the active table and names the ingress port of each period
`timescale 1ns/10ps
module phase_sequencer #(
  parameter logic [3:0] EGRESS_ID = 4'h0
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       enable,
  input  wire logic       advance,
  table_if.seq            tif,
  // Grant
  output logic [3:0]      grant_port,
  output logic [2:0]      grant_phase,
  output logic            grant_valid
);
  typedef struct packed {
    logic [2:0] idx;
    logic [3:0] port;
    logic       valid;
  } sq_t;
  localparam sq_t SQ_RST = '{idx: arb_table_pkg::IDX_LAST, port: '0, valid: 1'b0};
  sq_t s_r;
  sq_t s_nxt;

  // Next usable phase in ascending order, skipping bad entries at once
  always_comb begin
    logic [2:0] p;
    logic       found;
    p = '0;
    found = 1'b0;
    s_nxt = s_r;
    if (!enable) begin
      s_nxt = SQ_RST;
    end else if (advance) begin
      s_nxt.valid = 1'b0;
      for (int k = 1; k <= arb_table_pkg::PHASES; k++) begin
        p = s_r.idx + k[2:0];
        if (!found && arb_table_pkg::port_usable(tif.active[p*4 +: 4], EGRESS_ID)) begin
          found = 1'b1;
          s_nxt.idx = p;
          s_nxt.port = tif.active[p*4 +: 4];
          s_nxt.valid = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) s_r <= SQ_RST;
    else s_r <= s_nxt;
  end

  assign grant_port = s_r.port;
  assign grant_phase = s_r.idx;
  assign grant_valid = s_r.valid;
endmodule : phase_sequencer

// ==== verification/arb_table_checker.sv ====
// Bus and grant property checks for the arbitration table block
`timescale 1ns/10ps
module arb_table_checker #(
  parameter int         ADDR_W    = 12,
  parameter logic [3:0] EGRESS_ID = 4'h0
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Write channels
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  // Read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  // Grant
  input wire logic [3:0]        grant_port,
  input wire logic              grant_valid
);
  logic [ADDR_W-1:0] rd_addr_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Remember the address of the read in flight
  always_ff @(posedge aclk) begin
    if (arvalid && arready) begin
      rd_addr_r <= araddr;
    end
  end

  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response missing");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer missing");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_unmapped_zero: assert property (rvalid && rresp == arb_table_pkg::RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read data not zero");
  a_enable_reads: assert property (rvalid && rd_addr_r == arb_table_pkg::CTL_OFS |-> rdata[31] && !rdata[16])
    else $error("control readback wrong");
  a_status_spare: assert property (rvalid && rd_addr_r == arb_table_pkg::STS_OFS |-> rdata[31:2] == 30'h0)
    else $error("status spare bits set");
  a_grant_usable: assert property (grant_valid |-> grant_port inside {4'h0, 4'h2, 4'h3} && grant_port != EGRESS_ID)
    else $error("grant names unusable port");
endmodule : arb_table_checker

bind port_arbitration_table_status arb_table_checker #(.ADDR_W(ADDR_W), .EGRESS_ID(EGRESS_ID)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .grant_port(grant_port),
  .grant_valid(grant_valid)
);

// ==== verification/port_arbitration_table_status_test.sv ====
// Self-checking bench for the arbitration table block
`timescale 1ns/10ps
module port_arbitration_table_status_test;
  // Bench driven inputs
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [11:0] araddr = 12'h0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        fc_init_pending = 1'b0;
  logic        arb_advance = 1'b0;
  // Design outputs
  logic        awready, wready, bvalid, arready, rvalid, grant_valid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  grant_port;
  logic [2:0]  grant_phase;
  logic [31:0] dn_rdata;
  // Bench state
  int          seed = 32'h2e3d;
  int          failures = 0;
  int          total_checks = 0;
  logic [31:0] t, d;
  logic [1:0]  r;
  logic [2:0]  p;
  logic [7:0]  e;

  // Clock at 50 MHz
  always #10 aclk = ~aclk;

  port_arbitration_table_status dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .fc_init_pending(fc_init_pending),
    .arb_advance(arb_advance), .grant_port(grant_port), .grant_phase(grant_phase),
    .grant_valid(grant_valid), .irq(irq)
  );

  // Downstream instance on the same bus, answering in step with dut
  port_arbitration_table_status #(.UPSTREAM(1'b0)) dut_down (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(), .bresp(), .bvalid(),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(), .rdata(dn_rdata),
    .rresp(), .rvalid(), .rready(rready), .fc_init_pending(fc_init_pending),
    .arb_advance(arb_advance), .grant_port(), .grant_phase(), .grant_valid(), .irq()
  );

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Print the counts and the verdict, then end
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // Give up on a hung wait
  task automatic hang;
    failures++;
    $display("wrong value at %0t: wait timed out", $time);
    stop_test();
  endtask : hang

  // Bus write; bready rises only once bvalid is seen, so a held response is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (bvalid && bready) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b1;
    end while (n < 50);
    if (!(bvalid && bready)) hang();
    bready <= 1'b0;
  endtask : wr

  // Bus read; rready rises only once rvalid is seen, so held data is seen
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] s);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (rvalid && rready) break;
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b1;
    end while (n < 50);
    if (!(rvalid && rready)) hang();
    v = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask : rd

  // Read and compare one word
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    rd(a, d, r);
    chk(d, x);
  endtask : rdc

  // Poll until the coherency flag clears
  task automatic settle;
    int n;
    n = 0;
    do begin
      rd(arb_table_pkg::STS_OFS, d, r);
      n++;
    end while (d[0] !== 1'b0 && n < 30);
    chk(d, 32'h0);
    if (d[0] !== 1'b0) hang();
  endtask : settle

  // no reserved ids
  // Legal random table: every entry is id 1, 2 or 3, and id 1 names no port
  function automatic logic [31:0] rnd_tbl;
    logic [31:0] v;
    for (int i = 0; i < 8; i++) v[i*4 +: 4] = 4'h1 + 4'({$random(seed)} % 3);
    rnd_tbl = v;
  endfunction : rnd_tbl

  // Next served phase after q as {valid, phase, port}; ports 2 and 3 serve
  function automatic logic [7:0] nxt(input logic [31:0] v, input logic [2:0] q);
    logic [3:0] id;
    nxt = 8'h0;
    for (int i = 0; i < 8; i++) begin
      q = q + 3'h1;
      id = v[q*4 +: 4];
      if (!nxt[7] && (id == 4'h2 || id == 4'h3)) nxt = {1'b1, q, id};
    end
  endfunction : nxt

  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(arb_table_pkg::CTL_OFS, 32'h8000_0000);
    rdc(arb_table_pkg::STS_OFS, 32'h0);
    rdc(arb_table_pkg::TBL_OFS, 32'h1765_4321);
    rd(12'h3fc, d, r);
    chk({30'h0, r}, {30'h0, arb_table_pkg::RESP_SLVERR});
    wr(12'h3fc, 32'h0);
    chk({30'h0, bresp}, {30'h0, arb_table_pkg::RESP_SLVERR});
    $display("test reset done");
    repeat (4) begin
      t = rnd_tbl();
      wr(arb_table_pkg::TBL_OFS, t);
      rdc(arb_table_pkg::TBL_OFS, t);
    end
    rdc(arb_table_pkg::STS_OFS, 32'h0);
    wr(arb_table_pkg::STS_OFS, 32'hffff_ffff);
    chk({30'h0, bresp}, {30'h0, arb_table_pkg::RESP_OKAY});
    wr(arb_table_pkg::CTL_OFS, 32'h0002_0000);
    rdc(arb_table_pkg::STS_OFS, 32'h1);
    chk(dn_rdata, 32'h0);
    rdc(arb_table_pkg::CTL_OFS, 32'h8002_0000);
    wr(arb_table_pkg::CTL_OFS, 32'h0003_0000);
    rdc(arb_table_pkg::STS_OFS, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(arb_table_pkg::IMR_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rdc(arb_table_pkg::ISR_OFS, 32'h1);
    wr(arb_table_pkg::ISR_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    $display("test load done");
    fc_init_pending <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(arb_table_pkg::STS_OFS, 32'h2);
    fc_init_pending <= 1'b0;
    repeat (2) @(posedge aclk);
    rdc(arb_table_pkg::STS_OFS, 32'h0);
    rdc(arb_table_pkg::ISR_OFS, 32'h2);
    $display("test pending done");
    // Fixed table with skipped entries, then random tables
    for (int k = 0; k < 4; k++) begin
      t = (k == 0) ? 32'h1131_1112 : rnd_tbl();
      wr(arb_table_pkg::CTL_OFS, 32'h0);
      wr(arb_table_pkg::TBL_OFS, t);
      wr(arb_table_pkg::CTL_OFS, 32'h0003_0000);
      settle();
      p = 3'h7;
      repeat (10) begin
        arb_advance <= 1'b1;
        @(posedge aclk);
        arb_advance <= 1'b0;
        @(posedge aclk);
        e = nxt(t, p);
        if (e[7]) chk({24'h0, grant_valid, grant_phase, grant_port}, {24'h0, e});
        else chk({31'h0, grant_valid}, 32'h0);
        if (e[7]) p = e[6:4];
      end
    end
    $display("test sequence done");
    stop_test();
  end
endmodule : port_arbitration_table_status_test
